// *** design/sdt_pkg.sv ***
/*
 * sdt_pkg: shared constants of the standard down timer.
 * Assumes a 125 MHz aclk and an AXI4-Lite register port with 32-bit data.
 */
package sdt_pkg;

    // ************************************************************
    // register map (printed indices, byte address = index * 4)
    // ************************************************************
    localparam int          ADDR_W      = 12;
    localparam logic [7:0]  IDX_HIGH    = 8'hF0;
    localparam logic [7:0]  IDX_LOW     = 8'hF1;
    localparam logic [7:0]  IDX_PSC     = 8'hF2;
    localparam logic [7:0]  IDX_CTRL    = 8'hF3;
    localparam logic [11:0] ADDR_HIGH   = {2'h0, IDX_HIGH, 2'h0};
    localparam logic [11:0] ADDR_LOW    = {2'h0, IDX_LOW,  2'h0};
    localparam logic [11:0] ADDR_PSC    = {2'h0, IDX_PSC,  2'h0};
    localparam logic [11:0] ADDR_CTRL   = {2'h0, IDX_CTRL, 2'h0};

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]  CTRL_RST    = 8'h14;
    localparam logic [7:0]  BYTE_RST    = 8'hFF;
    localparam logic [15:0] CNT_RST     = 16'hFFFF;

    // ************************************************************
    // timer_control field positions
    // ************************************************************
    localparam int RUN_BIT      = 7;
    localparam int SINGLE_BIT   = 6;
    localparam int INMD_HI_BIT  = 5;
    localparam int INMD_LO_BIT  = 4;
    localparam int CLKSEL_BIT   = 3;
    localparam int IRQ_SOURCE_SELECT_BIT     = 2;
    localparam int OUTMD_HI_BIT = 1;
    localparam int OUTMD_LO_BIT = 0;

    // ************************************************************
    // clock source dividers (cycles of aclk, edges of oscillator)
    // ************************************************************
    localparam int INT_DIV      = 4;
    localparam int OSC_DIV      = 1024;

    // ************************************************************
    // bus answers and register selectors
    // ************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SDT_SEL_HIGH = 2'b00,
        SDT_SEL_LOW  = 2'b01,
        SDT_SEL_PSC  = 2'b10,
        SDT_SEL_CTRL = 2'b11
    } sdt_sel_e;

endpackage : sdt_pkg

// *** design/sdt_sync.sv ***
/*
 * sdt_sync: three-flop synchroniser for a pin level.
 * Assumes the input is asynchronous to aclk; output changes once stages two and three agree.
 */
`timescale 1ns/1ps
module sdt_sync #(
    parameter logic RST_LEVEL = 1'b0
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin_in,
    output logic      level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sdt_sync_s;

    sdt_sync_s st;
    sdt_sync_s next_st;

    // ************************************************************
    // shift chain; first stage is read only by the second
    // ************************************************************
    always_comb begin
        next_st     = st;
        next_st.s1  = pin_in;
        next_st.s2  = st.s1;
        next_st.s3  = st.s2;
        if (st.s2 == st.s3) begin
            next_st.lvl = st.s3;
        end
    end

    // registered state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= {4{RST_LEVEL}};
        end else begin
            st <= next_st;
        end
    end

    assign level = st.lvl;

endmodule : sdt_sync

// *** design/sdt_tick.sv ***
/*
 * sdt_tick: base tick of the timer, internal clock divided or oscillator edges divided.
 * Assumes osc_level is already synchronised to aclk.
 */
`timescale 1ns/1ps
module sdt_tick #(
    parameter int INT_DIV = sdt_pkg::INT_DIV,
    parameter int OSC_DIV = sdt_pkg::OSC_DIV
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic osc_sel,
    input  wire logic osc_level,
    output logic      tick
);

    localparam int IW = $clog2(INT_DIV);
    localparam int OW = $clog2(OSC_DIV);
    localparam logic [IW-1:0] INT_LAST = IW'(INT_DIV - 1);
    localparam logic [OW-1:0] OSC_LAST = OW'(OSC_DIV - 1);

    typedef struct packed {
        logic [IW-1:0] int_cnt;
        logic [OW-1:0] osc_cnt;
        logic          osc_prev;
        logic          tick;
    } sdt_tick_s;

    sdt_tick_s st;
    sdt_tick_s next_st;

    // ************************************************************
    // dividers; both run always so a source switch is glitch free
    // ************************************************************
    always_comb begin
        next_st          = st;
        next_st.osc_prev = osc_level;
        next_st.int_cnt  = (st.int_cnt == INT_LAST) ? '0 : st.int_cnt + 1'b1;
        if (osc_level && !st.osc_prev) begin
            next_st.osc_cnt = (st.osc_cnt == OSC_LAST) ? '0 : st.osc_cnt + 1'b1;
        end
        // source select
        if (osc_sel) begin
            next_st.tick = osc_level && !st.osc_prev && (st.osc_cnt == OSC_LAST);
        end else begin
            next_st.tick = (st.int_cnt == INT_LAST);
        end
    end

    // registered state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule : sdt_tick

// *** design/sdt_top.sv ***
/*
 * sdt_top: standard down timer with AXI4-Lite register access.
 * Assumes one 125 MHz clock, synchronous active-low reset, asynchronous
 * oscillator and external interrupt pins.
 */
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Summary of operation
// - 16-bit down counter behind an 8-bit prescaler, single or continuous mode.
// - prescaler fed by internal clock /4, or oscillator clock /1024 when selected.
// - counter reaching zero and underflowing is the end of count.
// - setting run bit starts counting next cycle; clearing it stops.
// - restart resumes held count, or loads a constant written while stopped.
// - while running, new constant waits for end of count; prescale applies at once.
// - single mode: end of count stops, reloads, clears run bit.
// - continuous mode: end of count reloads and keeps counting.
// - single select writable anytime, also together with start.
// - output mode zero drives the timer pin high.
// - output mode 01 toggles the pin at each end of count.
// - output mode high bit set copies low bit to pin at end of count.
// - interrupt source zero requests at each end of count; one passes pin.
// - timer request drives the shared external interrupt channel.
// - constant N gives a count length of N plus one.
// - counter byte reads return the live count.
// - control layout run7 single6 inmd5:4 clksel3 ints2 output_mode_high:0, reset 14h.
// - prescale divides by value plus one; reads return programmed value.
module sdt_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        oscillator_half_clock,
    input  wire logic        ext_irq_pin,
    output logic             timer_output_pin,
    output logic             irq_channel
);

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] cnst;
        logic [7:0]  psc;
        logic [15:0] cnt;
        logic [7:0]  pcnt;
        logic        pend;
        logic        pout;
        logic        irq;
        logic        aw_have;
        logic [11:0] aw_addr;
        logic        w_have;
        logic [7:0]  w_data;
        logic        w_lane0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
    } sdt_state_s;

    sdt_state_s st;
    sdt_state_s next_st;
    logic       base_tick;
    logic       ext_level;
    logic       osc_level;
    logic       cnt_tick;
    logic       eoc;
    logic       wr_now;
    logic       rd_now;
    logic [2:0] wr_dec;
    logic [2:0] rd_dec;

    // decode: bit 2 = mapped, bits 1:0 = register selector
    function automatic logic [2:0] sdt_decode(input logic [11:0] addr);
        unique case (addr)
            sdt_pkg::ADDR_HIGH: sdt_decode = {1'b1, sdt_pkg::SDT_SEL_HIGH};
            sdt_pkg::ADDR_LOW:  sdt_decode = {1'b1, sdt_pkg::SDT_SEL_LOW};
            sdt_pkg::ADDR_PSC:  sdt_decode = {1'b1, sdt_pkg::SDT_SEL_PSC};
            sdt_pkg::ADDR_CTRL: sdt_decode = {1'b1, sdt_pkg::SDT_SEL_CTRL};
            default:            sdt_decode = 3'h0;
        endcase
    endfunction : sdt_decode

    // ************************************************************
    // pin synchronisers and clock source
    // ************************************************************
    sdt_sync #(.RST_LEVEL(1'b0)) u_sync_ext (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  (ext_irq_pin),
        .level   (ext_level)
    );

    sdt_sync #(.RST_LEVEL(1'b0)) u_sync_osc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  (oscillator_half_clock),
        .level   (osc_level)
    );

    // input mode bits are not decoded: counting ticks of the selected clock source is the only mode here
    sdt_tick u_tick (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .osc_sel   (st.ctrl[sdt_pkg::CLKSEL_BIT]),
        .osc_level (osc_level),
        .tick      (base_tick)
    );

    // ************************************************************
    // next state: counting, then bus, bus write last so it wins
    // ************************************************************
    always_comb begin
        next_st  = st;
        cnt_tick = 1'b0;
        eoc      = 1'b0;
        wr_dec   = sdt_decode(st.aw_addr);
        rd_dec   = sdt_decode(s_axi_araddr);
        wr_now   = st.aw_have && st.w_have && !st.bvalid;
        rd_now   = s_axi_arvalid && st.arready;

        // prescaler divides by value plus one
        if (st.ctrl[sdt_pkg::RUN_BIT] && base_tick) begin
            if (st.pcnt == 8'h00) begin
                next_st.pcnt = st.psc;
                cnt_tick     = 1'b1;
            end else begin
                next_st.pcnt = st.pcnt - 8'h01;
            end
        end

        // underflow past zero ends the count, N+1 ticks per period
        if (cnt_tick) begin
            if (st.cnt == 16'h0000) begin
                eoc          = 1'b1;
                next_st.cnt  = st.cnst;
                next_st.pend = 1'b0;
                if (st.ctrl[sdt_pkg::SINGLE_BIT]) begin
                    next_st.ctrl[sdt_pkg::RUN_BIT] = 1'b0;
                end                                        // else keeps running
            end else begin
                next_st.cnt = st.cnt - 16'h0001;
            end
        end

        // output pin modes
        if (st.ctrl[1:0] == 2'b00) begin
            next_st.pout = 1'b1;
        end else if (eoc && st.ctrl[sdt_pkg::OUTMD_HI_BIT]) begin
            next_st.pout = st.ctrl[sdt_pkg::OUTMD_LO_BIT];
        end else if (eoc) begin
            next_st.pout = !st.pout;
        end

        // shared channel: timer end of count or the external pin
        next_st.irq = st.ctrl[sdt_pkg::IRQ_SOURCE_SELECT_BIT] ? ext_level : eoc;

        // write address and data taken in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_have  = 1'b1;
            next_st.w_data  = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // register write; lane 0 must be enabled for the byte to land
        if (wr_now) begin
            next_st.aw_have = 1'b0;
            next_st.w_have  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = wr_dec[2] ? sdt_pkg::RESP_OKAY : sdt_pkg::RESP_SLVERR;
            if (wr_dec[2] && st.w_lane0) begin
                unique case (sdt_pkg::sdt_sel_e'(wr_dec[1:0]))
                    sdt_pkg::SDT_SEL_HIGH: begin
                        next_st.cnst[15:8] = st.w_data;
                        next_st.pend       = 1'b1;
                    end
                    sdt_pkg::SDT_SEL_LOW: begin
                        next_st.cnst[7:0] = st.w_data;
                        next_st.pend      = 1'b1;
                    end
                    sdt_pkg::SDT_SEL_PSC: begin
                        next_st.psc  = st.w_data;
                        next_st.pcnt = st.w_data;          // immediate
                    end
                    sdt_pkg::SDT_SEL_CTRL: begin
                        next_st.ctrl = st.w_data;
                        // restart loads a constant written while stopped
                        if (st.w_data[sdt_pkg::RUN_BIT] && !st.ctrl[sdt_pkg::RUN_BIT] && st.pend) begin
                            next_st.cnt  = st.cnst;
                            next_st.pcnt = st.psc;
                            next_st.pend = 1'b0;
                        end
                    end
                endcase
            end
        end
        next_st.awready = !next_st.aw_have;
        next_st.wready  = !next_st.w_have;

        // reads: counter bytes return the live count
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (rd_now) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = rd_dec[2] ? sdt_pkg::RESP_OKAY : sdt_pkg::RESP_SLVERR;
            unique case (sdt_pkg::sdt_sel_e'(rd_dec[1:0]))
                sdt_pkg::SDT_SEL_HIGH: next_st.rdata = rd_dec[2] ? st.cnt[15:8] : 8'h00;
                sdt_pkg::SDT_SEL_LOW:  next_st.rdata = st.cnt[7:0] & {8{rd_dec[2]}};
                sdt_pkg::SDT_SEL_PSC:  next_st.rdata = st.psc;   // programmed value
                sdt_pkg::SDT_SEL_CTRL: next_st.rdata = st.ctrl;
            endcase
        end
        next_st.arready = !next_st.rvalid;
    end

    // ************************************************************
    // registered state; all ones for constant, count and prescale
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st         <= '0;
            st.ctrl    <= sdt_pkg::CTRL_RST;
            st.cnst    <= sdt_pkg::CNT_RST;
            st.cnt     <= sdt_pkg::CNT_RST;
            st.psc     <= sdt_pkg::BYTE_RST;
            st.pcnt    <= sdt_pkg::BYTE_RST;
            st.pout    <= 1'b1;
            st.awready <= 1'b1;
            st.wready  <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign s_axi_awready    = st.awready;
    assign s_axi_wready     = st.wready;
    assign s_axi_bvalid     = st.bvalid;
    assign s_axi_bresp      = st.bresp;
    assign s_axi_arready    = st.arready;
    assign s_axi_rvalid     = st.rvalid;
    assign s_axi_rdata      = {24'h000000, st.rdata};
    assign s_axi_rresp      = st.rresp;
    assign timer_output_pin = st.pout;
    assign irq_channel      = st.irq;

    // ************************************************************
    // assertions and covers
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_pin_idle_high: assert property ((st.ctrl[1:0] == 2'b00) |=> timer_output_pin)
        else $error("pin not high in no-output mode");
    chk_square_toggle: assert property (eoc && st.ctrl[1:0] == 2'b01 |=> timer_output_pin != $past(st.pout))
        else $error("square wave did not toggle");
    chk_pwm_copy: assert property (eoc && st.ctrl[1] |=> timer_output_pin == $past(st.ctrl[0]))
        else $error("pwm level not copied");
    chk_irq_timer: assert property (eoc && !st.ctrl[2] |=> irq_channel ##1 !irq_channel || eoc)
        else $error("timer request missing");
    chk_irq_pin: assert property (st.ctrl[2] |=> irq_channel == $past(ext_level))
        else $error("channel not following pin");
    chk_single_stop: assert property (eoc && st.ctrl[6] && !wr_now |=> !st.ctrl[7] && st.cnt == $past(st.cnst))
        else $error("single mode did not stop and reload");
    chk_cont_keep: assert property (eoc && !st.ctrl[6] && !wr_now |=> st.ctrl[7] && st.cnt == $past(st.cnst))
        else $error("continuous mode did not reload");
    chk_stop_hold: assert property (!st.ctrl[7] && !wr_now |=> st.cnt == $past(st.cnt))
        else $error("count moved while stopped");
    chk_read_live: assert property (rd_now && s_axi_araddr == sdt_pkg::ADDR_LOW
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(st.cnt[7:0]))
        else $error("live count not returned");
    chk_psc_now: assert property (wr_now && st.w_lane0 && st.aw_addr == sdt_pkg::ADDR_PSC
        |=> st.pcnt == $past(st.w_data) && st.psc == $past(st.w_data))
        else $error("prescale not applied at once");

    cov_single_end: cover property (eoc && st.ctrl[6]);
    cov_cont_end: cover property (eoc && !st.ctrl[6] ##1 st.ctrl[7]);
    cov_pwm_end: cover property (eoc && st.ctrl[1]);
    cov_read_high: cover property (rd_now && s_axi_araddr == sdt_pkg::ADDR_HIGH);

endmodule : sdt_top

// *** test/tb_standard_down_timer.sv ***
/*
 * tb_standard_down_timer: self-checking bench for sdt_top, with a register model kept in plain variables.
 * Assumes sdt_pkg and sdt_top are compiled first; the bench drives every port itself.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_standard_down_timer;
    // ************************************************************
    // signals and model state
    // ************************************************************
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  ws = 4'hF, wstrb = 4'hF;
    logic        osc = 1'b0, ext_pin = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, pin, irq;
    logic [1:0]  bresp, rresp, br;
    logic [31:0] rdata, rdv;
    logic [7:0]  m_ctrl = 8'h14, m_psc = 8'hFF;
    logic [15:0] m_cst = 16'hFFFF;
    logic        pv;
    int          miscompares = 0, checks = 0, cyc = 0, t0, t1, c, p, seed = 2147;

    sdt_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .oscillator_half_clock(osc),
        .ext_irq_pin(ext_pin), .timer_output_pin(pin), .irq_channel(irq));

    // 8 ns clock, free cycle count for period measurement
    always #4 aclk = ~aclk;
    // oscillator pin: 40 ns period, 1 ns offset so no edge meets an aclk edge; halves span two or three samples
    localparam int OSC_CYC = 5;
    initial begin #1; forever #20 osc = ~osc; end
    always @(posedge aclk) cyc <= cyc + 1;

    // ************************************************************
    // bus tasks: handshake signals sampled at the edge, changed by nba
    // ************************************************************
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wstrb <= ws; wvalid <= 1'b1; bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
            if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        br = bresp;
        bready <= 1'b0;
        // the model only takes writes that carry the low byte lane
        if (ws[0]) begin
            case (a)
                sdt_pkg::ADDR_HIGH: m_cst[15:8] = d;
                sdt_pkg::ADDR_LOW:  m_cst[7:0] = d;
                sdt_pkg::ADDR_PSC:  m_psc = d;
                sdt_pkg::ADDR_CTRL: m_ctrl = d;
                default: ;
            endcase
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rdv = rdata;
        rready <= 1'b0;
        `CHK(rdv, {24'h0, e})
        `CHK(rresp, er)
    endtask : rd

    // one-cycle channel pulse; bounded so a silent timer still ends
    task automatic wait_irq;
        int n;
        n = 0;
        do begin @(posedge aclk); n++; end while (irq !== 1'b1 && n < 12000);
        if (irq !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t: no request on the channel", $time);
        end
    endtask : wait_irq

    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(sdt_pkg::ADDR_HIGH, 8'hFF, sdt_pkg::RESP_OKAY);
        rd(sdt_pkg::ADDR_LOW, 8'hFF, sdt_pkg::RESP_OKAY);
        rd(sdt_pkg::ADDR_PSC, 8'hFF, sdt_pkg::RESP_OKAY);
        rd(sdt_pkg::ADDR_CTRL, sdt_pkg::CTRL_RST, sdt_pkg::RESP_OKAY);
        rd(12'h000, 8'h00, sdt_pkg::RESP_SLVERR);
        wr(12'h000, 8'h5A);
        `CHK(br, sdt_pkg::RESP_SLVERR)
        // a write without the low lane must leave the prescale untouched
        ws = 4'hE;
        wr(sdt_pkg::ADDR_PSC, 8'h00);
        ws = 4'hF;
        rd(sdt_pkg::ADDR_PSC, m_psc, sdt_pkg::RESP_OKAY);
        // single shot with square output, mode and start in one write
        wr(sdt_pkg::ADDR_PSC, 8'h00);
        wr(sdt_pkg::ADDR_HIGH, 8'h00);
        wr(sdt_pkg::ADDR_LOW, 8'h03);
        pv = pin;
        wr(sdt_pkg::ADDR_CTRL, 8'hC1);
        wait_irq;
        `CHK(pin, ~pv)
        m_ctrl[7] = 1'b0;
        repeat (3) @(posedge aclk);
        rd(sdt_pkg::ADDR_CTRL, m_ctrl, sdt_pkg::RESP_OKAY);
        rd(sdt_pkg::ADDR_LOW, m_cst[7:0], sdt_pkg::RESP_OKAY);
        // continuous runs: random constant and prescale, late constant change
        for (int k = 0; k < 3; k++) begin
            c = ($random(seed) & 15) + 4;
            p = $random(seed) & 3;
            wr(sdt_pkg::ADDR_PSC, p[7:0]);
            wr(sdt_pkg::ADDR_HIGH, 8'h00);
            wr(sdt_pkg::ADDR_LOW, c[7:0]);
            wr(sdt_pkg::ADDR_CTRL, 8'h81);
            wait_irq;
            t0 = cyc;
            pv = pin;
            wait_irq;
            `CHK(cyc - t0, (c + 1) * (p + 1) * 4)
            `CHK(pin, ~pv)
            t0 = cyc;
            wr(sdt_pkg::ADDR_LOW, 8'h02);
            wait_irq;
            t1 = cyc;
            `CHK(t1 - t0, (c + 1) * (p + 1) * 4)
            wait_irq;
            `CHK(cyc - t1, 3 * (p + 1) * 4)
            // stopping holds the live count
            wr(sdt_pkg::ADDR_CTRL, 8'h01);
            rd(sdt_pkg::ADDR_HIGH, 8'h00, sdt_pkg::RESP_OKAY);
        end
        // constant written while stopped is loaded at restart and read live
        wr(sdt_pkg::ADDR_PSC, 8'hFF);
        wr(sdt_pkg::ADDR_HIGH, 8'h12);
        wr(sdt_pkg::ADDR_LOW, 8'h34);
        wr(sdt_pkg::ADDR_CTRL, 8'h80);
        rd(sdt_pkg::ADDR_HIGH, 8'h12, sdt_pkg::RESP_OKAY);
        rd(sdt_pkg::ADDR_LOW, 8'h34, sdt_pkg::RESP_OKAY);
        `CHK(pin, 1'b1)
        // pwm: low mode bit copied to the pin at each end of count
        wr(sdt_pkg::ADDR_CTRL, 8'h00);
        wr(sdt_pkg::ADDR_PSC, 8'h00);
        wr(sdt_pkg::ADDR_HIGH, 8'h00);
        wr(sdt_pkg::ADDR_LOW, 8'h05);
        wr(sdt_pkg::ADDR_CTRL, 8'h82);
        wait_irq;
        `CHK(pin, 1'b0)
        wr(sdt_pkg::ADDR_CTRL, 8'h83);
        wait_irq;
        `CHK(pin, 1'b1)
        // oscillator time base, constant and prescale zero, input mode bits kept at zero
        wr(sdt_pkg::ADDR_CTRL, 8'h00);
        wr(sdt_pkg::ADDR_LOW, 8'h00);
        wr(sdt_pkg::ADDR_CTRL, 8'h89);
        wait_irq;
        t0 = cyc;
        wait_irq;
        `CHK(cyc - t0, sdt_pkg::OSC_DIV * OSC_CYC)
        // external pin feeds the channel; timer stopped first so no request is pending at the switch
        wr(sdt_pkg::ADDR_CTRL, 8'h00);
        wr(sdt_pkg::ADDR_CTRL, 8'h04);
        ext_pin <= 1'b1;
        repeat (8) @(posedge aclk);
        `CHK(irq, 1'b1)
        ext_pin <= 1'b0;
        repeat (8) @(posedge aclk);
        `CHK(irq, 1'b0)
        rd(sdt_pkg::ADDR_CTRL, m_ctrl, sdt_pkg::RESP_OKAY);
        test_done;
    end

    // hang guard, well beyond the longest expected run
    initial begin
        repeat (40000) @(posedge aclk);
        miscompares++;
        test_done;
    end
endmodule : tb_standard_down_timer
